// ===== src/timer0_consts.svh
// Constants for the eight-bit timer with its shared prescaler.
// Assumes inclusion by bare name from the timer design files only.
`ifndef TIMER0_CONSTS_SVH
`define TIMER0_CONSTS_SVH

// Reset and limit values of the count register.
`define T0_COUNT_RST     8'h00
`define T0_COUNT_MAX     8'hFF
`define T0_COUNT_ONE     8'h01

// Reset value of the shared prescaler chain.
`define T0_PRESC_RST     8'h00

// Instruction cycles of increment inhibit after a count write.
`define T0_INHIBIT_CYC   2'h2
`define T0_INHIBIT_NONE  2'h0
`define T0_INHIBIT_STEP  2'h1

// Reset value of the three-flop pin synchroniser.
`define T0_SYNC_RST      3'h0

`endif

// ===== src/timer0_pkg.sv
// Types shared by the timer, its prescaler and the pin synchroniser.
// Assumes nothing beyond a SystemVerilog compiler.
package timer0_pkg;

  // Phases of one instruction cycle, Gray coded along the ring.
  typedef enum logic [1:0] {
    PH_Q1 = 2'h0,
    PH_Q2 = 2'h1,
    PH_Q3 = 2'h3,
    PH_Q4 = 2'h2
  } phase_t;

  // Configuration bits that software sets for the timer.
  typedef struct packed {
    logic       clock_source_select;
    logic       source_edge_select;
    logic       prescaler_assign;
    logic [2:0] prescale_rate;
  } option_t;

  // Whole state of the timer module.
  typedef struct packed {
    phase_t     phase;
    logic [7:0] count;
    logic [7:0] presc;
    logic [1:0] inhibit;
    logic       pending;
    logic       flag;
    logic       watchdog_tick;
  } timer_state_t;

  // Whole state of the pin synchroniser.
  typedef struct packed {
    logic [2:0] sync;
    logic       level;
    logic       edge_seen;
  } sync_state_t;

endpackage : timer0_pkg

// ===== src/edge_sync.sv
// Three-flop synchroniser and edge detector for the count input pin.
// Assumes the pin is asynchronous to clock_i.
`timescale 1ns/1ps
`include "timer0_consts.svh"

module edge_sync (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic falling_i,
  output logic      edge_o
);

  timer0_pkg::sync_state_t st_r;
  timer0_pkg::sync_state_t st_nxt;
  logic                    agree;

  // The first flop feeds only the second; a new level is taken once
  // the second and third flops agree, and an edge of the selected polarity is flagged.
  always_comb begin
    st_nxt      = st_r;
    st_nxt.sync = {st_r.sync[1:0], pin_i};
    agree       = (st_r.sync[1] == st_r.sync[2]);
    st_nxt.edge_seen = 1'b0;
    if (agree && (st_r.sync[2] != st_r.level)) begin
      st_nxt.level     = st_r.sync[2];
      st_nxt.edge_seen = falling_i ? ~st_r.sync[2] : st_r.sync[2];
    end
  end

  // State register.
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '{sync: `T0_SYNC_RST, level: 1'b0, edge_seen: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign edge_o = st_r.edge_seen;

endmodule : edge_sync

// ===== src/timer0_prescaled.sv
// Eight-bit timer/counter with a prescaler shared with the watchdog.
// Summary of operation
// R1 - Eight-bit count register, readable and writable, counting upward.
// R2 - Source select clear: increment once per instruction cycle, no prescale.
// R3 - After a count write, increments stop for two instruction cycles.
// R4 - Source select set: count edges of the external count input.
// R5 - One prescaler serves timer or watchdog; assign bit clear gives timer.
// R6 - The shared prescaler is an eight-bit divider chain.
// R7 - Assigned to timer: eight ratios 1:2 to 1:256 by prescale rate.
// R8 - Undivided 1:1 timer rate only while prescaler serves the watchdog.
// R9 - Prescaler count is neither readable nor writable by software.
// R10 - Timer-assigned prescaler is cleared by every count register write.
// R11 - Watchdog-owned prescaler is cleared by the watchdog clear instruction.
// R12 - Rollover from FFh to 00h sets the overflow flag until cleared.
// R13 - Edge select one counts falling edges, zero counts rising edges.
// R14 - Assign bit set routes the prescaler to the watchdog.
// R15 - Counter mode samples prescaler output at Q2 and Q4 before counting.
// R16 - Timer divide ratio is two to the power of rate plus one.
// R17 - Software preloads two counts ahead to cover the write inhibit.
//
// Assumes clock_i is four times the instruction rate (Q1 to Q4 phases),
// control pulses come from logic on clock_i, and the count pin is
// asynchronous.
`timescale 1ns/1ps
`include "timer0_consts.svh"

module timer0_prescaled (
  input  wire logic                  clock_i,
  input  wire logic                  rst_n_i,
  input  wire timer0_pkg::option_t   option_i,
  input  wire logic                  count_wr_i,
  input  wire logic [7:0]            count_wdata_i,
  input  wire logic                  watchdog_clear_instruction_i,
  input  wire logic                  flag_clear_i,
  input  wire logic                  watchdog_base_tick_i,
  input  wire logic                  external_count_input_i,
  output logic [7:0]                 count_register_o,
  output logic                       overflow_flag_o,
  output logic                       watchdog_tick_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************

  timer0_pkg::timer_state_t st_r;
  timer0_pkg::timer_state_t st_nxt;
  logic                     ext_edge;
  logic                     q4;
  logic                     sample;
  logic                     src_tick;
  logic                     presc_step;
  logic [7:0]               presc_inc;
  logic                     tmr_rise;
  logic                     watchdog_rise;
  logic [2:0]               watchdog_idx;
  logic                     tmr_event;
  logic                     inc;
  logic                     roll;

  // ****************************************************************
  // Count input synchroniser
  // ****************************************************************

  // Edge polarity follows the source edge select bit.
  edge_sync u_edge_sync (  // [R13]
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (external_count_input_i),
    .falling_i (option_i.source_edge_select),
    .edge_o    (ext_edge)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Phase ring, prescaler chain, count register and flag.
  always_comb begin
    st_nxt = st_r;

    // Four phases make one instruction cycle.
    case (st_r.phase)
      timer0_pkg::PH_Q1: st_nxt.phase = timer0_pkg::PH_Q2;
      timer0_pkg::PH_Q2: st_nxt.phase = timer0_pkg::PH_Q3;
      timer0_pkg::PH_Q3: st_nxt.phase = timer0_pkg::PH_Q4;
      timer0_pkg::PH_Q4: st_nxt.phase = timer0_pkg::PH_Q1;
      default:           st_nxt.phase = timer0_pkg::PH_Q1;
    endcase

    q4     = (st_r.phase == timer0_pkg::PH_Q4);
    sample = (st_r.phase == timer0_pkg::PH_Q2) || q4;

    // Counter mode counts pin edges, timer mode instruction cycles.
    src_tick = option_i.clock_source_select ? ext_edge : q4;  // [R2] [R4]

    // One prescaler, fed by the timer source or the watchdog base.
    presc_step = option_i.prescaler_assign ? watchdog_base_tick_i
                                           : src_tick;  // [R5] [R14]
    presc_inc  = st_r.presc + `T0_COUNT_ONE;  // [R6]
    if (presc_step) begin
      st_nxt.presc = presc_inc;
    end

    // A rise of chain bit N divides by two to the power N plus one.
    tmr_rise = presc_step && !st_r.presc[option_i.prescale_rate]
               && presc_inc[option_i.prescale_rate];  // [R7] [R16]

    // The watchdog side runs one step faster, with 1:1 at rate zero.
    watchdog_idx  = option_i.prescale_rate - 3'h1;
    watchdog_rise = (option_i.prescale_rate == 3'h0) ? presc_step
                    : (presc_step && !st_r.presc[watchdog_idx]
                       && presc_inc[watchdog_idx]);  // [R14]

    // Without the prescaler the timer takes every source tick.
    tmr_event = option_i.prescaler_assign ? src_tick
                                          : tmr_rise;  // [R8]
    st_nxt.watchdog_tick = option_i.prescaler_assign && watchdog_rise;

    // Chain clears depend on which side owns the prescaler.
    if (count_wr_i && !option_i.prescaler_assign) begin
      st_nxt.presc = `T0_PRESC_RST;  // [R10]
    end
    if (watchdog_clear_instruction_i && option_i.prescaler_assign) begin
      st_nxt.presc = `T0_PRESC_RST;  // [R11]
    end

    // Counter mode holds the event until the next Q2 or Q4 sample.
    inc = 1'b0;
    if (option_i.clock_source_select) begin
      if (sample) begin
        inc            = st_r.pending;  // [R15]
        st_nxt.pending = tmr_event;
      end else begin
        st_nxt.pending = st_r.pending || tmr_event;
      end
    end else begin
      inc            = tmr_event;
      st_nxt.pending = 1'b0;
    end

    // Inhibit runs down one step at the end of each instruction cycle.
    if (st_r.inhibit != `T0_INHIBIT_NONE) begin
      inc = 1'b0;  // [R3]
      if (q4) begin
        st_nxt.inhibit = st_r.inhibit - `T0_INHIBIT_STEP;
      end
    end

    // A write wins over an increment in the same cycle.
    roll = 1'b0;
    if (count_wr_i) begin
      st_nxt.count   = count_wdata_i;  // [R1]
      st_nxt.inhibit = `T0_INHIBIT_CYC;  // [R3]
      st_nxt.pending = 1'b0;
    end else if (inc) begin
      st_nxt.count = st_r.count + `T0_COUNT_ONE;  // [R1]
      roll         = (st_r.count == `T0_COUNT_MAX);
    end

    // Rollover sets the flag; a set beats a clear in the same cycle.
    st_nxt.flag = (st_r.flag && !flag_clear_i) || roll;  // [R12]
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // The prescaler count stays internal, with no port to read it.
  always_ff @(posedge clock_i or negedge rst_n_i) begin  // [R9]
    if (!rst_n_i) begin
      st_r <= '{phase:    timer0_pkg::PH_Q1,
                count:    `T0_COUNT_RST,
                presc:    `T0_PRESC_RST,
                inhibit:  `T0_INHIBIT_NONE,
                pending:  1'b0,
                flag:     1'b0,
                watchdog_tick: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign count_register_o = st_r.count;
  assign overflow_flag_o  = st_r.flag;
  assign watchdog_tick_o  = st_r.watchdog_tick;

  // ****************************************************************
  // Assertions
  // ****************************************************************

  // A write shows in the count register one edge later.
  a_write_loads: assert property ( // [R1]
    @(posedge clock_i) disable iff (!rst_n_i)
    count_wr_i |=> (count_register_o == $past(count_wdata_i)))
    else $error("count write not loaded");

  // Two instruction cycles after a write the count does not move.
  a_write_inhibit: assert property ( // [R3]
    @(posedge clock_i) disable iff (!rst_n_i)
    (count_wr_i && st_r.phase == timer0_pkg::PH_Q1)
    ##1 (!count_wr_i) [*8] |-> $stable(count_register_o))
    else $error("count moved during write inhibit");

  // Timer mode without prescaler steps once per instruction cycle.
  a_timer_rate: assert property ( // [R2] [R8]
    @(posedge clock_i) disable iff (!rst_n_i)
    (!option_i.clock_source_select && option_i.prescaler_assign
     && q4 && st_r.inhibit == `T0_INHIBIT_NONE && !count_wr_i)
    |=> (count_register_o == $past(count_register_o) + `T0_COUNT_ONE))
    else $error("timer did not step at end of cycle");

  // Timer mode without prescaler never steps outside Q4.
  a_timer_q4_only: assert property ( // [R2]
    @(posedge clock_i) disable iff (!rst_n_i)
    (!option_i.clock_source_select && !q4 && !count_wr_i)
    |=> $stable(count_register_o))
    else $error("timer stepped outside Q4");

  // Rollover from FFh to 00h raises the flag with it.
  a_flag_on_roll: assert property ( // [R12]
    @(posedge clock_i) disable iff (!rst_n_i)
    (count_register_o == `T0_COUNT_MAX && !count_wr_i)
    ##1 (count_register_o == `T0_COUNT_RST) |-> overflow_flag_o)
    else $error("rollover did not set the flag");

  // The flag holds until software clears it.
  a_flag_sticky: assert property ( // [R12]
    @(posedge clock_i) disable iff (!rst_n_i)
    (overflow_flag_o && !flag_clear_i) |=> overflow_flag_o)
    else $error("overflow flag dropped by itself");

  // A write clears a timer-owned prescaler.
  a_presc_wr_clr: assert property ( // [R10]
    @(posedge clock_i) disable iff (!rst_n_i)
    (count_wr_i && !option_i.prescaler_assign)
    |=> (st_r.presc == `T0_PRESC_RST))
    else $error("write left prescaler uncleared");

  // The watchdog clear empties a watchdog-owned prescaler.
  a_presc_wdt_clr: assert property ( // [R11]
    @(posedge clock_i) disable iff (!rst_n_i)
    (watchdog_clear_instruction_i && option_i.prescaler_assign)
    |=> (st_r.presc == `T0_PRESC_RST))
    else $error("watchdog clear left prescaler uncleared");

  // A timer event with the prescaler lands where chain bit rate rises.
  a_div_ratio: assert property ( // [R7] [R16]
    @(posedge clock_i) disable iff (!rst_n_i)
    (tmr_event && !option_i.prescaler_assign)
    |-> ((presc_inc & ((8'h02 << option_i.prescale_rate) - 8'h01))
         == (8'h01 << option_i.prescale_rate)))
    else $error("timer event off the divide boundary");

  // In counter mode the count moves only after a Q2 or Q4 sample.
  a_counter_sample: assert property ( // [R4] [R15]
    @(posedge clock_i) disable iff (!rst_n_i)
    (option_i.clock_source_select && !count_wr_i && !sample)
    |=> $stable(count_register_o))
    else $error("counter moved outside Q2 or Q4");

  // A write arms the two-cycle inhibit.
  a_write_arms_inhibit: assert property ( // [R3]
    @(posedge clock_i) disable iff (!rst_n_i)
    count_wr_i |=> (st_r.inhibit == `T0_INHIBIT_CYC))
    else $error("count write did not arm the inhibit");

  // While the inhibit runs, only a write moves the count.
  a_inhibit_holds: assert property ( // [R3]
    @(posedge clock_i) disable iff (!rst_n_i)
    (st_r.inhibit != `T0_INHIBIT_NONE && !count_wr_i)
    |=> $stable(count_register_o))
    else $error("count moved while inhibited");

  // Each prescaler step adds one to the chain unless a clear hits it.
  a_presc_steps: assert property ( // [R6]
    @(posedge clock_i) disable iff (!rst_n_i)
    (presc_step && !count_wr_i && !watchdog_clear_instruction_i)
    |=> (st_r.presc == $past(st_r.presc) + `T0_COUNT_ONE))
    else $error("prescaler chain did not step");

  // A timer-owned prescaler sends no ticks to the watchdog.
  a_watchdog_gated: assert property ( // [R5]
    @(posedge clock_i) disable iff (!rst_n_i)
    !option_i.prescaler_assign |=> !watchdog_tick_o)
    else $error("watchdog ticked without the prescaler");

  // At rate zero a watchdog-owned prescaler passes every base tick.
  a_watchdog_direct: assert property ( // [R14]
    @(posedge clock_i) disable iff (!rst_n_i)
    (option_i.prescaler_assign && option_i.prescale_rate == 3'h0
     && watchdog_base_tick_i)
    |=> watchdog_tick_o)
    else $error("watchdog base tick was not passed on");

  // A clear drops the flag unless a rollover lands in the same cycle.
  a_flag_clears: assert property ( // [R12]
    @(posedge clock_i) disable iff (!rst_n_i)
    (flag_clear_i && count_register_o != `T0_COUNT_MAX)
    |=> !overflow_flag_o)
    else $error("flag clear was ignored");

endmodule : timer0_prescaled

// ===== verification/count_pin_model.sv
// Behavioural model of the external source on the count input pin.
// Assumes the bench calls its tasks and clock_i is the block clock.
`timescale 1ns/1ps

module count_pin_model (
  input  wire logic clock_i,
  output logic      pin_o
);
  // The pin starts low, so no stray edge follows reset.
  initial begin
    pin_o = 1'b0;
  end

  // Sets one level at an edge and holds it for two instruction cycles.
  task automatic set_level(input logic v);
    @(posedge clock_i);
    pin_o <= v;
    repeat (8) @(posedge clock_i);
  endtask : set_level

  // Whole pulses, each level held long enough to be sampled.
  task automatic pulse(input int n);
    repeat (n) begin
      set_level(1'b1);
      set_level(1'b0);
    end
  endtask : pulse
endmodule : count_pin_model

// ===== verification/timer0_prescaled_test.sv
// Self-checking bench for the eight-bit timer and its shared prescaler.
// Assumes the design files and count_pin_model are compiled first.
`timescale 1ns/1ps

module timer0_prescaled_test;
  logic                clock_i;
  logic                rst_n_i;
  timer0_pkg::option_t option;
  logic                count_wr;
  logic [7:0]          count_wdata;
  logic                wd_clear;
  logic                flag_clear;
  logic                base_tick;
  logic                pin;
  logic [7:0]          count;
  logic                flag;
  logic                watchdog_tick;
  int                  miscompares;
  int                  num_checks;
  int                  watchdog_pulses;
  int                  n;
  int                  snap;

  // ****************************************
  // Clock, design and partner
  // ****************************************
  // Free-running 200 MHz clock.
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end

  timer0_prescaled i_timer0_prescaled (
    .clock_i                      (clock_i),
    .rst_n_i                      (rst_n_i),
    .option_i                     (option),
    .count_wr_i                   (count_wr),
    .count_wdata_i                (count_wdata),
    .watchdog_clear_instruction_i (wd_clear),
    .flag_clear_i                 (flag_clear),
    .watchdog_base_tick_i         (base_tick),
    .external_count_input_i       (pin),
    .count_register_o             (count),
    .overflow_flag_o              (flag),
    .watchdog_tick_o              (watchdog_tick)
  );

  count_pin_model i_count_pin_model (
    .clock_i (clock_i),
    .pin_o   (pin)
  );

  // Counts watchdog pulses so tests can compare differences.
  always @(posedge clock_i) begin
    if (watchdog_tick === 1'b1) begin
      watchdog_pulses <= watchdog_pulses + 1;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out

  // Waits k rising edges, then settles at the falling edge for sampling.
  task automatic tick(input int k);
    repeat (k) @(posedge clock_i);
    @(negedge clock_i);
  endtask : tick

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("BAD %0t got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask : chk

  task automatic chk_range(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      $display("BAD %0t value %0d outside %0d..%0d", $time, v, lo, hi);
      miscompares++;
    end
  endtask : chk_range

  // Counts falling edges until the count moves; a stuck count ends the run.
  task automatic wait_change(input int lim, output int cyc);
    logic [7:0] old;
    old = count;
    cyc = 0;
    while (count === old && cyc < lim) begin
      @(negedge clock_i);
      cyc++;
    end
    if (cyc >= lim) begin
      $display("BAD %0t count did not move", $time);
      miscompares++;
      close_out();
    end
  endtask : wait_change

  task automatic set_opt(input logic cs, se, pa, input logic [2:0] r);
    @(posedge clock_i);
    option <= timer0_pkg::option_t'({cs, se, pa, r});
  endtask : set_opt

  task automatic write_count(input logic [7:0] d);
    @(posedge clock_i);
    count_wr    <= 1'b1;
    count_wdata <= d;
    @(posedge clock_i);
    count_wr    <= 1'b0;
    @(negedge clock_i); // The loaded value is settled here.
  endtask : write_count

  // One-cycle strobes: 0 clears the watchdog, 1 clears the flag.
  task automatic strobe(input int sel);
    @(posedge clock_i);
    if (sel == 0) wd_clear <= 1'b1;
    else flag_clear <= 1'b1;
    @(posedge clock_i);
    wd_clear   <= 1'b0;
    flag_clear <= 1'b0;
  endtask : strobe

  task automatic send_ticks(input int k);
    repeat (k) begin
      @(posedge clock_i);
      base_tick <= 1'b1;
      @(posedge clock_i);
      base_tick <= 1'b0;
      repeat (2) @(posedge clock_i);
    end
    tick(4);
  endtask : send_ticks

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n_i = 1'b0;
    option = '0;
    count_wr = 1'b0;
    count_wdata = 8'h00;
    wd_clear = 1'b0;
    flag_clear = 1'b0;
    base_tick = 1'b0;
    miscompares = 0;
    num_checks = 0;
    watchdog_pulses = 0;
    repeat (12) @(posedge clock_i);
    rst_n_i <= 1'b1;
    tick(2);
    chk(count, 8'h00);
    chk({6'h00, flag, watchdog_tick}, 8'h00);
    // Undivided timer: inhibit after a write, then one count per cycle.
    set_opt(1'b0, 1'b0, 1'b1, 3'h0);
    write_count(8'h40);
    chk(count, 8'h40);
    wait_change(40, n);
    // Software needing exact intervals preloads two counts ahead.
    chk_range(n, 9, 12);
    chk(count, 8'h41);
    wait_change(40, n);
    chk_range(n, 4, 4);
    // Every timer prescale ratio, measured between two increments.
    for (int r = 0; r < 8; r++) begin
      set_opt(1'b0, 1'b0, 1'b0, 3'(r));
      write_count(8'h00);
      wait_change(1100, n);
      wait_change(1100, n);
      chk_range(n, 4 << (r + 1), 4 << (r + 1));
    end
    // A write late in a prescale period restarts the period.
    set_opt(1'b0, 1'b0, 1'b0, 3'h3);
    write_count(8'h00);
    wait_change(300, n);
    tick(47);
    write_count(8'h80);
    wait_change(300, n);
    chk_range(n, 28, 80);
    // Rollover sets a sticky flag that only a clear removes.
    set_opt(1'b0, 1'b0, 1'b1, 3'h0);
    strobe(1);
    write_count(8'hFD);
    wait_change(40, n);
    wait_change(40, n);
    chk({7'h00, flag}, 8'h00);
    wait_change(40, n);
    chk({flag, count[6:0]}, 8'h80);
    wait_change(40, n);
    chk({7'h00, flag}, 8'h01);
    strobe(1);
    tick(1);
    chk({7'h00, flag}, 8'h00);
    // Pin edges in counter mode, each polarity in turn.
    for (int s = 0; s < 2; s++) begin
      set_opt(1'b1, 1'(s), 1'b1, 3'h0);
      write_count(8'h00);
      tick(16);
      i_count_pin_model.set_level(1'b1);
      tick(8);
      chk(count, (s == 0) ? 8'h01 : 8'h00);
      i_count_pin_model.set_level(1'b0);
      tick(8);
      chk(count, 8'h01);
    end
    // Counter mode through the prescaler at 1:2.
    set_opt(1'b1, 1'b0, 1'b0, 3'h0);
    write_count(8'h00);
    tick(16);
    i_count_pin_model.pulse(4);
    tick(8);
    chk(count, 8'h02);
    // Watchdog ratios with the prescaler routed away from the timer.
    for (int r = 0; r < 8; r++) begin
      set_opt(1'b0, 1'b0, 1'b1, 3'(r));
      strobe(0);
      snap = watchdog_pulses;
      send_ticks(256);
      chk_range(watchdog_pulses - snap, 256 >> r, 256 >> r);
    end
    set_opt(1'b0, 1'b0, 1'b0, 3'h0);
    snap = watchdog_pulses;
    send_ticks(16);
    chk_range(watchdog_pulses - snap, 0, 0);
    // A watchdog clear discards the prescaler's partial count.
    set_opt(1'b0, 1'b0, 1'b1, 3'h2);
    strobe(0);
    send_ticks(1);
    strobe(0);
    snap = watchdog_pulses;
    send_ticks(1);
    chk_range(watchdog_pulses - snap, 0, 0);
    send_ticks(3);
    chk_range(watchdog_pulses - snap, 1, 1);
    close_out();
  end
endmodule : timer0_prescaled_test
